/* File: common/mfi_cfg.svh */
// Constants for the multi-I/O serial flash interface block
`ifndef MFI_CFG_SVH
`define MFI_CFG_SVH

// ==========================================================
// Instruction codes
`define MFI_OP_PP        8'h02
`define MFI_OP_FAST_RD   8'h0B
`define MFI_OP_DOR       8'h3B
`define MFI_OP_DIOR      8'hBB
`define MFI_OP_QOR       8'h6B
`define MFI_OP_QIOR      8'hEB
`define MFI_OP_QPP       8'h32
`define MFI_OP_DDR_FR    8'h0D
`define MFI_OP_DDR_DIOR  8'hBD
`define MFI_OP_DDR_QIOR  8'hED

// ==========================================================
// Field sizes
`define MFI_ADDR_BITS    6'h18
`define MFI_ADDR_MODE_BITS 6'h20
`define MFI_BYTE_BITS    4'h8
`define MFI_FILL_BYTE    8'hFF
`define MFI_DLP_CYCLES   5'h04
`define MFI_FIFO_DEPTH   16
`define MFI_FIFO_WIDTH   9

// ==========================================================
// Latency cycles per latency code
`define MFI_SDR_LAT0     5'h08
`define MFI_SDR_LAT1     5'h04
`define MFI_SDR_LAT2     5'h02
`define MFI_SDR_LAT3     5'h00
`define MFI_DDR_LAT0     5'h06
`define MFI_DDR_LAT1     5'h04
`define MFI_DDR_LAT2     5'h02
`define MFI_DDR_LAT3     5'h01

`endif

/* File: common/mfi_pkg.sv */
// Types shared by the serial flash interface block
package mfi_pkg;

   // ==========================================================
   // Interface states
   typedef enum logic [2:0] {
      MFI_IDLE,
      MFI_INSTR,
      MFI_ADDR,
      MFI_LAT,
      MFI_OUT,
      MFI_IN,
      MFI_SKIP
   } mfi_state_type;

   // ==========================================================
   // Transfer format picked by the instruction
   typedef struct packed {
      logic valid;
      logic needQuad;
      logic isRead;
      logic isDdr;
      logic [2:0] addrLanes;
      logic [2:0] dataLanes;
      logic [5:0] addrBits;
   } mfi_cmd_type;

endpackage : mfi_pkg

/* File: hdl/mfi_sync.sv */
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
`default_nettype none
module mfi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= RST;
         dout <= RST;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule : mfi_sync
`default_nettype wire

/* File: hdl/mfi_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module mfi_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0] wrPtr_r;
   logic [AW:0] rdPtr_r;
   wire logic doWrite;
   wire logic doRead;

   assign inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(D);
   assign outValid = wrPtr_r != rdPtr_r;
   assign doWrite = inValid & inReady;
   assign doRead = outValid & outReady;
   assign outData = mem[rdPtr_r[AW-1:0]];

   always_ff @(posedge core_clk) begin
      if (doWrite) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         wrPtr_r <= wrPtr_r + (AW+1)'(doWrite);
         rdPtr_r <= rdPtr_r + (AW+1)'(doRead);
      end
   end
endmodule : mfi_fifo
`default_nettype wire

/* File: hdl/mfi_ctrl.sv */
// Interface state machine of a multi-I/O serial flash device
// What this block does
// R1: Quad off: shared pin is hold input.
// R2: Hold freezes command, ignores inputs, floats outputs.
// R3: Hold release resumes the exact prior state.
// R4: Quad on: shared pin is data line three.
// R5: DDR commands ignore hold and write protect.
// R6: Dual/quad output reads: address on SI only.
// R7: Single-rate reads take latency from latency code.
// R8: Latency: inputs ignored, nothing driven but the learning pattern, protect ignored.
// R9: Host releases lines before last latency falling edge.
// R10: Single output drives SO until chip select.
// R11: Dual I/O address two bits, then latency/output.
// R12: Dual output drives IO0/IO1 until deselect.
// R13: Quad program/output read address on IO0 only.
// R14: Quad program takes four data bits per cycle.
// R15: Quad I/O address four bits, then latency/output.
// R16: Quad output drives four lines until deselect.
// R17: DDR fast read: one address bit per edge.
// R18: DDR dual read: two address bits per edge.
// R19: DDR quad read: four address bits per edge.
// R20: DDR reads have at least one latency cycle.
// R21: Learning pattern only in last four latency cycles.
// R22: DDR output uses one, two or four lines.
// R23: Quad commands refused unless quad enable set.
// R24: Eight-bit instruction, MSB first, on rising edges.
`timescale 1ns/1ns
`default_nettype none
`include "mfi_cfg.svh"
module mfi_ctrl (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Serial link pins
   input wire logic sckPin,
   input wire logic csPinN,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   // Configuration levels
   input wire logic quadEnable,
   input wire logic [1:0] latencyCode,
   input wire logic patternEnable,
   input wire logic [7:0] patternByte,
   // Received byte stream
   output logic rxValid,
   input wire logic rxReady,
   output logic [8:0] rxData,
   // Read data stream
   input wire logic rdValid,
   output logic rdReady,
   input wire logic [7:0] rdData,
   // Status
   output logic busy,
   output logic holdActive,
   output logic rxOverrun,
   output logic cmdRejected
);
   import mfi_pkg::*;

   // ==========================================================
   // Format tables
   function automatic mfi_cmd_type decodeCmd(input logic [7:0] op);
      mfi_cmd_type c;
      c = '0;
      c.addrLanes = 3'h1;
      c.dataLanes = 3'h1;
      c.addrBits = `MFI_ADDR_BITS;
      c.valid = 1'b1;
      c.isRead = 1'b1;
      unique case (op)
         `MFI_OP_PP: c.isRead = 1'b0;
         `MFI_OP_FAST_RD: ;
         `MFI_OP_DOR: c.dataLanes = 3'h2; // [R6]
         `MFI_OP_DIOR: begin
            c.addrLanes = 3'h2; // [R11]
            c.dataLanes = 3'h2;
            c.addrBits = `MFI_ADDR_MODE_BITS;
         end
         `MFI_OP_QOR: begin
            c.dataLanes = 3'h4; // [R13]
            c.needQuad = 1'b1;
         end
         `MFI_OP_QIOR: begin
            c.addrLanes = 3'h4; // [R15]
            c.dataLanes = 3'h4;
            c.addrBits = `MFI_ADDR_MODE_BITS;
            c.needQuad = 1'b1;
         end
         `MFI_OP_QPP: begin
            c.dataLanes = 3'h4; // [R14]
            c.needQuad = 1'b1;
            c.isRead = 1'b0;
         end
         `MFI_OP_DDR_FR: begin
            c.isDdr = 1'b1; // [R17]
            c.addrBits = `MFI_ADDR_MODE_BITS;
         end
         `MFI_OP_DDR_DIOR: begin
            c.isDdr = 1'b1; // [R18]
            c.addrLanes = 3'h2;
            c.dataLanes = 3'h2;
            c.addrBits = `MFI_ADDR_MODE_BITS;
         end
         `MFI_OP_DDR_QIOR: begin
            c.isDdr = 1'b1; // [R19]
            c.addrLanes = 3'h4;
            c.dataLanes = 3'h4;
            c.addrBits = `MFI_ADDR_MODE_BITS;
            c.needQuad = 1'b1;
         end
         default: c = '0;
      endcase
      return c;
   endfunction : decodeCmd

   function automatic logic [4:0] latCycles(input logic ddr,
                                            input logic [1:0] code);
      logic [4:0] n;
      unique case (code)
         2'h0: n = ddr ? `MFI_DDR_LAT0 : `MFI_SDR_LAT0;
         2'h1: n = ddr ? `MFI_DDR_LAT1 : `MFI_SDR_LAT1;
         2'h2: n = ddr ? `MFI_DDR_LAT2 : `MFI_SDR_LAT2;
         2'h3: n = ddr ? `MFI_DDR_LAT3 : `MFI_SDR_LAT3;
      endcase
      // DDR never runs without a latency cycle
      if (ddr && n == 5'h00) begin
         n = 5'h01; // [R20]
      end
      return n;
   endfunction : latCycles

   // ==========================================================
   // Pin synchronisers and clock edge detection
   wire logic [5:0] pinSync;
   wire logic sckS;
   wire logic csNS;
   wire logic [3:0] ioS;
   logic sckPrev_r;

   mfi_sync #(.W(6), .RST(6'h10)) pinSyncU (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .din({sckPin, csPinN, ioIn}),
      .dout(pinSync)
   );

   assign sckS = pinSync[5];
   assign csNS = pinSync[4];
   assign ioS = pinSync[3:0];

   // ==========================================================
   // State
   mfi_state_type state_r, state_nxt;
   mfi_cmd_type cmd_r, cmd_nxt;
   logic [5:0] addrLeft_r, addrLeft_nxt;
   logic [7:0] inByte_r, inByte_nxt;
   logic [3:0] inBits_r, inBits_nxt;
   logic [4:0] latLeft_r, latLeft_nxt;
   logic [2:0] dlpIdx_r, dlpIdx_nxt;
   logic [7:0] outShift_r, outShift_nxt;
   logic [3:0] outLeft_r, outLeft_nxt;
   logic [3:0] ioOut_r, ioOut_nxt;
   logic [3:0] ioOe_r, ioOe_nxt;
   logic started_r, started_nxt;
   logic pushValid_r, pushValid_nxt;
   logic [8:0] pushData_r, pushData_nxt;
   logic overrun_r, overrun_nxt;
   logic rejected_r, rejected_nxt;

   // ==========================================================
   // Edge qualification and lane selection
   wire logic sckRise;
   wire logic sckFall;
   wire logic edgeOk;
   wire logic capEdge;
   wire logic launchEdge;
   wire logic [2:0] inLanes;
   wire logic [7:0] capByte;
   wire logic [3:0] inBitsSum;
   wire logic [4:0] latRem;
   wire logic dlpOn;
   wire logic doLaunch;
   wire logic [7:0] outByte;
   wire logic [7:0] outShifted;
   wire logic [3:0] laneBits;
   wire logic [3:0] laneOe;
   wire logic [3:0] outBase;
   wire logic pushReady;
   wire mfi_cmd_type opCmd;

   assign sckRise = sckS & ~sckPrev_r;
   assign sckFall = ~sckS & sckPrev_r;
   // Shared pin is hold only with quad off and outside DDR
   assign holdActive = ~csNS & ~quadEnable & ~cmd_r.isDdr // [R1] [R4] [R5]
                       & ~ioS[3] & (state_r != MFI_IDLE);
   // Hold swallows edges so the state simply stands still
   assign edgeOk = ~holdActive; // [R2] [R3]
   assign capEdge = edgeOk & (sckRise // [R24]
                    | (cmd_r.isDdr & started_r & sckFall)); // [R17]
   assign launchEdge = edgeOk & (sckFall | (cmd_r.isDdr & sckRise));

   // Only the format's own lanes are read; the rest are ignored
   assign inLanes = (state_r == MFI_INSTR) ? 3'h1 :
                    (state_r == MFI_ADDR) ? cmd_r.addrLanes :
                    cmd_r.dataLanes;
   assign capByte = (inLanes == 3'h4) ? {inByte_r[3:0], ioS} : // [R19]
                    (inLanes == 3'h2) ? {inByte_r[5:0], ioS[1:0]} :
                    {inByte_r[6:0], ioS[0]}; // [R13] [R6]
   assign inBitsSum = inBits_r + {1'b0, inLanes};
   assign opCmd = decodeCmd(capByte);

   // Latency cycles still to run once this edge is taken
   assign latRem = sckFall ? (latLeft_r - 5'h01) : latLeft_r;
   assign dlpOn = cmd_r.isDdr & patternEnable // [R21]
                  & (latRem <= `MFI_DLP_CYCLES) & (latRem != 5'h00);

   assign doLaunch = launchEdge & ((state_r == MFI_OUT)
                     | ((state_r == MFI_LAT) & sckFall
                        & (latLeft_r == 5'h01)));
   assign rdReady = doLaunch & (outLeft_r == 4'h0);
   // Starved read data shows as the fill byte, not stale bits
   assign outByte = (outLeft_r != 4'h0) ? outShift_r :
                    (rdValid ? rdData : `MFI_FILL_BYTE);
   assign outShifted = (cmd_r.dataLanes == 3'h4) ? {outByte[3:0], 4'h0} :
                       (cmd_r.dataLanes == 3'h2) ? {outByte[5:0], 2'h0} :
                       {outByte[6:0], 1'b0};
   assign outBase = (outLeft_r == 4'h0) ? `MFI_BYTE_BITS : outLeft_r;
   assign laneBits = (cmd_r.dataLanes == 3'h4) ? outByte[7:4] : // [R16]
                     (cmd_r.dataLanes == 3'h2) ? {2'h0, outByte[7:6]} :
                     {2'h0, outByte[7], 1'b0}; // [R10] [R22]
   assign laneOe = (cmd_r.dataLanes == 3'h4) ? 4'hF :
                   (cmd_r.dataLanes == 3'h2) ? 4'h3 : 4'h2; // [R12] [R22]

   // ==========================================================
   // Next-state logic
   always_comb begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      addrLeft_nxt = addrLeft_r;
      inByte_nxt = inByte_r;
      inBits_nxt = inBits_r;
      latLeft_nxt = latLeft_r;
      dlpIdx_nxt = dlpIdx_r;
      outShift_nxt = outShift_r;
      outLeft_nxt = outLeft_r;
      ioOut_nxt = ioOut_r;
      ioOe_nxt = ioOe_r;
      started_nxt = started_r;
      pushValid_nxt = 1'b0;
      pushData_nxt = pushData_r;
      overrun_nxt = overrun_r | (pushValid_r & ~pushReady);
      rejected_nxt = rejected_r;
      if (csNS) begin
         state_nxt = MFI_IDLE;
         cmd_nxt = '0;
         inBits_nxt = 4'h0;
         outLeft_nxt = 4'h0;
         ioOe_nxt = 4'h0;
         started_nxt = 1'b0;
      end else begin
         unique case (state_r)
            MFI_IDLE: begin
               state_nxt = MFI_INSTR;
               overrun_nxt = pushValid_r & ~pushReady;
               rejected_nxt = 1'b0;
            end
            MFI_INSTR: begin
               if (capEdge) begin
                  inByte_nxt = capByte; // [R24]
                  inBits_nxt = inBitsSum;
                  if (inBitsSum == `MFI_BYTE_BITS) begin
                     inBits_nxt = 4'h0;
                     pushValid_nxt = 1'b1;
                     pushData_nxt = {1'b1, capByte};
                     cmd_nxt = opCmd;
                     addrLeft_nxt = opCmd.addrBits;
                     if (!opCmd.valid) begin
                        state_nxt = MFI_SKIP;
                     end else if (opCmd.needQuad && !quadEnable) begin
                        state_nxt = MFI_SKIP; // [R23]
                        rejected_nxt = 1'b1;
                        cmd_nxt = '0;
                     end else begin
                        state_nxt = MFI_ADDR;
                     end
                  end
               end
            end
            MFI_ADDR: begin
               if (edgeOk && sckRise) begin
                  started_nxt = 1'b1;
               end
               if (capEdge) begin
                  inByte_nxt = capByte;
                  inBits_nxt = inBitsSum;
                  addrLeft_nxt = addrLeft_r - {3'h0, cmd_r.addrLanes};
                  if (inBitsSum == `MFI_BYTE_BITS) begin
                     inBits_nxt = 4'h0;
                     pushValid_nxt = 1'b1;
                     pushData_nxt = {1'b0, capByte};
                  end
                  if (addrLeft_r == {3'h0, cmd_r.addrLanes}) begin
                     dlpIdx_nxt = 3'h7;
                     if (cmd_r.isRead) begin
                        // SDR address ends on a rise, so one more fall
                        state_nxt = MFI_LAT; // [R11] [R15]
                        latLeft_nxt = latCycles(cmd_r.isDdr, latencyCode)
                           + {4'h0, ~cmd_r.isDdr}; // [R7] [R20]
                     end else begin
                        state_nxt = MFI_IN; // [R14]
                     end
                  end
               end
            end
            MFI_LAT: begin
               // Lines stay released unless the learning pattern runs
               ioOe_nxt = 4'h0; // [R8] [R9]
               if (launchEdge && dlpOn) begin
                  ioOut_nxt = {4{patternByte[dlpIdx_r]}}; // [R21]
                  ioOe_nxt = 4'hF;
                  dlpIdx_nxt = dlpIdx_r - 3'h1;
               end else if (!launchEdge) begin
                  ioOe_nxt = ioOe_r;
               end
               if (edgeOk && sckFall) begin
                  if (latLeft_r == 5'h01) begin
                     state_nxt = MFI_OUT; // [R12] [R16]
                  end else begin
                     latLeft_nxt = latLeft_r - 5'h01;
                  end
               end
            end
            MFI_OUT: ; // Output runs until chip select rises [R10]
            MFI_IN: begin
               if (capEdge) begin
                  inByte_nxt = capByte; // [R14]
                  inBits_nxt = inBitsSum;
                  if (inBitsSum == `MFI_BYTE_BITS) begin
                     inBits_nxt = 4'h0;
                     pushValid_nxt = 1'b1;
                     pushData_nxt = {1'b0, capByte};
                  end
               end
            end
            MFI_SKIP: ;
            default: state_nxt = MFI_IDLE;
         endcase
         if (doLaunch) begin
            ioOut_nxt = laneBits;
            ioOe_nxt = laneOe;
            outShift_nxt = outShifted;
            outLeft_nxt = outBase - {1'b0, cmd_r.dataLanes};
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sckPrev_r <= 1'b0;
         state_r <= MFI_IDLE;
         cmd_r <= '0;
         addrLeft_r <= 6'h00;
         inByte_r <= 8'h00;
         inBits_r <= 4'h0;
         latLeft_r <= 5'h00;
         dlpIdx_r <= 3'h7;
      end else begin
         sckPrev_r <= sckS;
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         addrLeft_r <= addrLeft_nxt;
         inByte_r <= inByte_nxt;
         inBits_r <= inBits_nxt;
         latLeft_r <= latLeft_nxt;
         dlpIdx_r <= dlpIdx_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         outShift_r <= 8'h00;
         outLeft_r <= 4'h0;
         ioOut_r <= 4'h0;
         ioOe_r <= 4'h0;
         started_r <= 1'b0;
         pushValid_r <= 1'b0;
         pushData_r <= 9'h000;
         overrun_r <= 1'b0;
         rejected_r <= 1'b0;
      end else begin
         outShift_r <= outShift_nxt;
         outLeft_r <= outLeft_nxt;
         ioOut_r <= ioOut_nxt;
         ioOe_r <= ioOe_nxt;
         started_r <= started_nxt;
         pushValid_r <= pushValid_nxt;
         pushData_r <= pushData_nxt;
         overrun_r <= overrun_nxt;
         rejected_r <= rejected_nxt;
      end
   end

   // ==========================================================
   // Received byte buffer
   // The link cannot be stalled, so a full buffer drops and flags
   mfi_fifo #(.W(`MFI_FIFO_WIDTH), .D(`MFI_FIFO_DEPTH)) rxFifoU (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .inValid(pushValid_r),
      .inReady(pushReady),
      .inData(pushData_r),
      .outValid(rxValid),
      .outReady(rxReady),
      .outData(rxData)
   );

   // ==========================================================
   // Outputs
   assign ioOut = ioOut_r;
   assign ioOe = holdActive ? 4'h0 : ioOe_r; // [R2]
   assign busy = state_r != MFI_IDLE;
   assign rxOverrun = overrun_r;
   assign cmdRejected = rejected_r;

endmodule : mfi_ctrl
`default_nettype wire

/* File: dv/mfi_ctrl_asserts.sv */
// Properties of the flash interface block
`timescale 1ns/1ns
`default_nettype none
module mfi_ctrl_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Watched ports
   input wire logic csPinN,
   input wire logic quadEnable,
   input wire logic [3:0] ioOe,
   input wire logic rxValid,
   input wire logic rdReady,
   input wire logic busy,
   input wire logic holdActive,
   input wire logic rxOverrun,
   input wire logic cmdRejected
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // Sequences and properties
   sequence s_idle2;
      !busy [*2];
   endsequence
   sequence s_fetchEnd;
      busy ##1 !rdReady;
   endsequence
   property p_csRelease;
      $rose(csPinN) |-> ##[1:6] ioOe == 4'h0;
   endproperty
   property p_idleQuiet;
      s_idle2 |-> ioOe == 4'h0;
   endproperty
   property p_fetchPulse;
      rdReady |-> s_fetchEnd;
   endproperty
   property p_holdFloat;
      holdActive |-> ioOe == 4'h0 && !rdReady;
   endproperty
   property p_laneShape;
      ioOe inside {4'h0, 4'h2, 4'h3, 4'hF};
   endproperty
   a_csRelease: assert property (p_csRelease)
      else $error("driven after deselect");
   a_idleQuiet: assert property (p_idleQuiet)
      else $error("driven while idle");
   a_fetchPulse: assert property (p_fetchPulse)
      else $error("fetch not one cycle");
   a_holdFloat: assert property (p_holdFloat)
      else $error("hold activity");
   a_holdPin: assert property (holdActive |-> !quadEnable)
      else $error("hold in quad mode");
   a_rejectQuiet: assert property (cmdRejected |-> ioOe == 4'h0)
      else $error("refused drives lines");
   a_laneShape: assert property (p_laneShape)
      else $error("bad lane set");
   a_overrunFull: assert property ($rose(rxOverrun) |-> rxValid)
      else $error("overrun when empty");
endmodule : mfi_ctrl_asserts
bind mfi_ctrl mfi_ctrl_asserts u_chk (.*);
`default_nettype wire

/* File: dv/mfi_host_model.sv */
// Host controller model of the link
`timescale 1ns/1ns
`default_nettype none
module mfi_host_model (
   // Clock
   input wire logic core_clk,
   // Link
   input wire logic quadEnable,
   input wire logic [3:0] ioIn,
   output logic sckPin,
   output logic csPinN,
   output logic [3:0] hostIo,
   output logic [3:0] hostOe
);
   logic [31:0] got;
   logic [31:0] shiftR;
   initial begin
      sckPin = 1'b0;
      csPinN = 1'b1;
      hostIo = 4'h0;
      hostOe = 4'h0;
   end
   // ==========================================================
   // Half SCK period, data set clear of the edge
   task automatic hop(input logic [3:0] d, input logic [3:0] oe, input int w);
      repeat (2) @(negedge core_clk);
      hostIo = d;
      hostOe = oe;
      repeat (2) @(negedge core_clk);
      if (w == 1) got = {got[30:0], ioIn[1]};
      if (w == 2) got = {got[29:0], ioIn[1:0]};
      if (w == 4) got = {got[27:0], ioIn};
      sckPin = ~sckPin;
   endtask : hop
   // ==========================================================
   // One command from select to deselect
   task automatic run(input logic [7:0] op, input logic [31:0] adr,
         input int aBits, input int aw, input logic ddr, input int lat,
         input int ow, input int oBits, output logic [31:0] res,
         input int nibs = 0, input int holdAt = 99);
      logic [3:0] keep, d, oe;
      keep = quadEnable ? 4'h0 : 4'h8;
      oe = keep | ((4'h1 << aw) - 4'h1);
      got = 32'h0000_0000;
      shiftR = adr << (32 - aBits);
      csPinN = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         repeat (2) hop({3'b100, op[i]}, keep | 4'h1, 0);
      end
      for (int b = 0; b < aBits; b += aw) begin
         d = shiftR[31:28] >> (4 - aw);
         shiftR = shiftR << aw;
         repeat (ddr ? 1 : 2) hop(d | (keep & 4'h8), oe, 0);
      end
      for (int k = 0; k < nibs; k++) begin
         repeat (2) hop(k[3:0], 4'hF, 0);
      end
      repeat (2 * lat) hop(4'h8, ddr ? 4'h0 : keep, 0);
      for (int k = 0; k < oBits / ow; k++) begin
         if (k == holdAt) begin
            repeat (3) @(negedge core_clk);
            hostIo[3] = 1'b0;
            repeat (12) @(negedge core_clk);
            hostIo[3] = 1'b1;
            repeat (4) @(negedge core_clk);
         end
         hop(4'h8, keep, ow);
         if (!ddr) hop(4'h8, keep, 0);
      end
      repeat (2) @(negedge core_clk);
      csPinN = 1'b1;
      hostOe = 4'h0;
      sckPin = 1'b0;
      repeat (8) @(negedge core_clk);
      res = got;
   endtask : run
endmodule : mfi_host_model
`default_nettype wire

/* File: dv/multi_io_serial_flash_interface_tb.sv */
// Bench for the flash interface block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
$display("mismatch %s exp %0h got %0h", n, e, g); end end
module multi_io_serial_flash_interface_tb;
   logic core_clk = 0, arst_n = 0, quadEnable = 0, patternEnable = 0;
   logic rxReady = 0, took = 0, sawHold = 0, noise = 0;
   logic [1:0] latencyCode = 2'h3;
   logic [7:0] rdByte = 8'h00;
   logic [31:0] res;
   logic [8:0] rxData;
   logic [3:0] ioOut, ioOe, ioIn, hostIo, hostOe;
   logic sckPin, csPinN, rxValid, rdReady, busy, holdActive, rxOverrun;
   logic cmdRejected;
   int errors = 0, cmp_count = 0;
   initial forever #20 core_clk = ~core_clk;
   // ==========================================================
   // Design wins, then host, else pull-up or noise
   assign ioIn = (ioOe & ioOut) | (~ioOe & hostOe & hostIo)
      | (~ioOe & ~hostOe & {1'b1, {3{noise}}});
   always @(negedge core_clk) begin
      noise <= ~noise;
      took <= rdReady;
      if (took) rdByte <= rdByte + 8'h11;
      if (holdActive === 1'b1) sawHold <= 1'b1;
   end
   mfi_ctrl u_dut (.*, .patternByte(8'h5A), .rdValid(1'b1),
      .rdData(rdByte));
   mfi_host_model u_host (.*);
   // ==========================================================
   // Buffer access
   task automatic pop(input logic [8:0] exp);
      for (int n = 0; n < 50 && rxValid !== 1'b1; n++) @(negedge core_clk);
      `CHK("rx byte", exp, rxData)
      rxReady = 1'b1;
      @(negedge core_clk);
      rxReady = 1'b0;
      @(negedge core_clk);
   endtask : pop
   task automatic flush;
      rxReady = 1'b1;
      repeat (40) @(negedge core_clk);
      rxReady = 1'b0;
   endtask : flush
   // ==========================================================
   // Scenarios
   task automatic t_single;
      `CHK("idle drive", 4'h0, ioOe)
      rdByte = 8'hA5;
      u_host.run(8'h0B, 32'h0012_3456, 24, 1, 0, 0, 1, 16, res, 0, 3);
      `CHK("hold resume", 16'hA5B6, res[15:0])
      `CHK("hold seen", 1'b1, sawHold)
      pop(9'h10B);
      pop(9'h012);
      pop(9'h034);
      pop(9'h056);
   endtask : t_single
   task automatic t_latency;
      int lat [4] = '{8, 4, 2, 0};
      for (int c = 0; c < 4; c++) begin
         latencyCode = c[1:0];
         rdByte = 8'h3C;
         u_host.run(8'h0B, 32'h0, 24, 1, 0, lat[c], 1, 8, res);
         `CHK("latency data", 8'h3C, res[7:0])
      end
      flush;
   endtask : t_latency
   task automatic t_dual;
      rdByte = 8'h96;
      u_host.run(8'h3B, 32'h0000_0100, 24, 1, 0, 0, 2, 16, res);
      `CHK("dual out", 16'h96A7, res[15:0])
      rdByte = 8'h69;
      u_host.run(8'hBB, 32'h0001_00A0, 32, 2, 0, 0, 2, 16, res);
      `CHK("dual io", 16'h697A, res[15:0])
      u_host.run(8'h6B, 32'h0, 24, 1, 0, 0, 4, 8, res);
      `CHK("quad refused", 1'b1, cmdRejected)
      quadEnable = 1'b1;
      rdByte = 8'hC3;
      u_host.run(8'h6B, 32'h0, 24, 1, 0, 0, 4, 16, res);
      `CHK("quad out", 16'hC3D4, res[15:0])
      rdByte = 8'h5A;
      u_host.run(8'hEB, 32'h0000_0300, 32, 4, 0, 0, 4, 16, res);
      `CHK("quad io", 16'h5A6B, res[15:0])
      flush;
   endtask : t_dual
   task automatic t_ddr;
      quadEnable = 1'b0;
      sawHold = 1'b0;
      rdByte = 8'h81;
      u_host.run(8'h0D, 32'h0000_0400, 32, 1, 1, 1, 1, 16, res, 0, 4);
      `CHK("ddr single", 16'h8192, res[15:0])
      `CHK("ddr no hold", 1'b0, sawHold)
      quadEnable = 1'b1;
      rdByte = 8'h42;
      u_host.run(8'hBD, 32'h0000_0500, 32, 2, 1, 1, 2, 16, res);
      `CHK("ddr dual", 16'h4253, res[15:0])
      rdByte = 8'h24;
      u_host.run(8'hED, 32'h0000_0600, 32, 4, 1, 1, 4, 16, res);
      `CHK("ddr quad", 16'h2435, res[15:0])
      latencyCode = 2'h0;
      patternEnable = 1'b1;
      u_host.run(8'hED, 32'h0, 32, 4, 1, 2, 4, 32, res);
      `CHK("learning pattern", 32'h0F0F_F0F0, res)
      flush;
   endtask : t_ddr
   task automatic t_fifo;
      logic [7:0] v = 8'h01;
      u_host.run(8'h32, 32'h0000_0200, 24, 1, 0, 0, 1, 0, res, 40);
      `CHK("overrun", 1'b1, rxOverrun)
      pop(9'h132);
      pop(9'h000);
      pop(9'h002);
      pop(9'h000);
      for (int i = 0; i < 12; i++) begin
         pop({1'b0, v});
         v = {v[3:0] + 4'h1, v[3:0] + 4'h2};
      end
      `CHK("buffer empty", 1'b0, rxValid)
   endtask : t_fifo
   // ==========================================================
   // Verdict
   task automatic wrap_up;
      $display("checks %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      #3_000_000;
      errors++;
      wrap_up;
   end
   initial begin
      repeat (8) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      t_single;
      t_latency;
      t_dual;
      t_ddr;
      t_fifo;
      wrap_up;
   end
endmodule : multi_io_serial_flash_interface_tb
`default_nettype wire
